// File: rtl/mot_pkg.sv
// Register map, field positions, reset values and timing of the task command block
`default_nettype none
package mot_pkg;
	// Word offsets of the Wishbone register map (byte addresses)
	localparam logic [7:0]  OFS_CMD         = 8'h00;
	localparam logic [7:0]  OFS_SEQ         = 8'h04;
	localparam logic [7:0]  OFS_TEACH       = 8'h08;
	localparam logic [7:0]  OFS_ACK         = 8'h0C;
	localparam logic [7:0]  OFS_STAT        = 8'h10;
	localparam logic [7:0]  OFS_POS         = 8'h14;
	localparam logic [7:0]  OFS_MCODE       = 8'h18;
	localparam logic [7:0]  OFS_TPOS        = 8'h1C;
	// Command and acknowledge bit positions
	localparam int          CB_SEQ_EN       = 0;
	localparam int          CB_START        = 1;
	localparam int          CB_INDIV        = 2;
	localparam int          CB_MRESET       = 4;
	localparam int          CB_TEACH        = 5;
	localparam int          CB_STOP         = 15;
	localparam logic [15:0] CMD_USED_MASK   = 16'h8037;
	// Status bit positions
	localparam int          SB_BUSY         = 0;
	localparam int          SB_START_OK     = 1;
	localparam int          SB_STOP_IN      = 4;
	localparam int          SB_STROBE       = 6;
	localparam int          SB_INVALID      = 8;
	localparam int          SB_STOPPED_EXEC = 12;
	localparam int          SB_COMPLETED    = 13;
	// Reset values
	localparam logic [15:0] RST_WORD        = 16'h0000;
	localparam logic [15:0] RST_SEQ_LAST    = 16'h00FF;
	// Deceleration time to standstill and sequence step time
	localparam int          DECEL_US        = 20;
	localparam int          CLK_MHZ         = 25;
	localparam int          DECEL_CYC       = DECEL_US * CLK_MHZ;
	localparam int          STEP_CYC        = 16;
endpackage
`default_nettype wire

// File: rtl/mot_task_cmd.sv
// Memory operation task command and status interpreter with a Wishbone slave
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`default_nettype none
module mot_task_cmd #(
	parameter int          DECEL_CYCLES = mot_pkg::DECEL_CYC,
	parameter int          STEP_CYCLES  = mot_pkg::STEP_CYC,
	parameter logic [15:0] SEQ_LAST     = mot_pkg::RST_SEQ_LAST
) (
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	// Wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// Motion side
	input  wire logic        i_axis_busy,
	input  wire logic [31:0] i_present_pos,
	input  wire logic [15:0] i_seq_code,
	input  wire logic        i_seq_end,
	input  wire logic        i_seq_error,
	output logic      [15:0] o_seq_index,
	output logic             o_running,
	output logic             o_teach_we,
	output logic      [15:0] o_teach_addr,
	output logic      [31:0] o_teach_data
);
	typedef enum {ST_IDLE, ST_RUN, ST_DECEL} mot_state_t;

	typedef struct packed {
		mot_state_t  state;
		logic [15:0] cmd;
		logic [15:0] seq_no;
		logic [15:0] teach_no;
		logic [15:0] ack;
		logic        invalid;
		logic        strobe;
		logic        stopped_exec;
		logic        completed;
		logic        indiv;
		logic [15:0] seq;
		logic [15:0] mcode;
		logic [31:0] timer;
		logic        teach_we;
		logic [31:0] teach_data;
		logic [31:0] rdata;
		logic        wb_ack;
		logic        axis_s1;
		logic        axis_s2;
	} mot_regs_t;

	mot_regs_t r;
	mot_regs_t next_r;
	logic [15:0] status;
	logic [15:0] wdat;
	logic        wr_req;
	logic        busy;
	logic [15:0] rise;

	// Axis busy arrives from another domain; only the second stage is used
	assign busy = (r.state != ST_IDLE) || r.axis_s2 || r.strobe;
	always_comb begin
		status = 16'h0000;
		status[mot_pkg::SB_BUSY]         = busy;
		status[mot_pkg::SB_START_OK]     = !busy;
		status[mot_pkg::SB_STOP_IN]      = (r.state == ST_DECEL);
		status[mot_pkg::SB_STROBE]       = r.strobe;
		status[mot_pkg::SB_INVALID]      = r.invalid;
		status[mot_pkg::SB_STOPPED_EXEC] = r.stopped_exec;
		status[mot_pkg::SB_COMPLETED]    = r.completed;
	end

	assign wr_req = i_wb_cyc && i_wb_stb && i_wb_we && !r.wb_ack;
	assign wdat   = {i_wb_sel[1] ? i_wb_dat[15:8] : 8'h00, i_wb_sel[0] ? i_wb_dat[7:0] : 8'h00};
	// Commands are acted on once per host assertion: ack blocks a repeat
	assign rise   = r.cmd & ~r.ack;

	always_comb begin
		next_r          = r;
		next_r.teach_we = 1'b0;
		next_r.axis_s1  = i_axis_busy;
		next_r.axis_s2  = r.axis_s1;
		next_r.wb_ack   = i_wb_cyc && i_wb_stb && !r.wb_ack;
		next_r.rdata    = 32'h0000_0000;
		// Register writes; partial byte lanes merge with the old word
		if (wr_req) begin
			case (i_wb_adr)
				mot_pkg::OFS_CMD: begin
					next_r.cmd = ((r.cmd & {{8{~i_wb_sel[1]}}, {8{~i_wb_sel[0]}}}) | wdat)
						& mot_pkg::CMD_USED_MASK;
				end
				mot_pkg::OFS_SEQ: begin
					next_r.seq_no = (r.seq_no & {{8{~i_wb_sel[1]}}, {8{~i_wb_sel[0]}}}) | wdat;
				end
				mot_pkg::OFS_TEACH: begin
					next_r.teach_no = (r.teach_no & {{8{~i_wb_sel[1]}}, {8{~i_wb_sel[0]}}}) | wdat;
				end
				default: begin
				end
			endcase
		end
		if (i_wb_cyc && i_wb_stb && !i_wb_we && !r.wb_ack) begin
			case (i_wb_adr)
				mot_pkg::OFS_CMD:   next_r.rdata = {16'h0000, r.cmd};
				mot_pkg::OFS_SEQ:   next_r.rdata = {16'h0000, r.seq_no};
				mot_pkg::OFS_TEACH: next_r.rdata = {16'h0000, r.teach_no};
				mot_pkg::OFS_ACK:   next_r.rdata = {16'h0000, r.ack};
				mot_pkg::OFS_STAT:  next_r.rdata = {16'h0000, status};
				mot_pkg::OFS_POS:   next_r.rdata = {16'h0000, r.seq};
				mot_pkg::OFS_MCODE: next_r.rdata = {16'h0000, r.mcode};
				mot_pkg::OFS_TPOS:  next_r.rdata = r.teach_data;
				default:            next_r.rdata = 32'h0000_0000;
			endcase
		end
		// Ack falls once host drops the command bit
		next_r.ack = r.ack & r.cmd;
		// Sequence number enable
		if (rise[mot_pkg::CB_SEQ_EN]) begin
			next_r.ack[mot_pkg::CB_SEQ_EN] = 1'b1;
		end
		// Stop has priority over start in the same cycle
		if (rise[mot_pkg::CB_STOP]) begin
			next_r.ack[mot_pkg::CB_STOP] = 1'b1;
			if (r.state == ST_RUN) begin
				next_r.state = ST_DECEL;
				next_r.timer = 32'(DECEL_CYCLES);
			end
		end else if ((rise[mot_pkg::CB_START] || rise[mot_pkg::CB_INDIV]) && r.state != ST_DECEL) begin
			// Decelerating: no ack, start stays pending until stop ends
			next_r.ack[mot_pkg::CB_START] = r.cmd[mot_pkg::CB_START];
			next_r.ack[mot_pkg::CB_INDIV] = r.cmd[mot_pkg::CB_INDIV];
			if (busy) begin
				next_r.invalid = 1'b1;
			end else begin
				next_r.state        = ST_RUN;
				next_r.invalid      = 1'b0;
				next_r.completed    = 1'b0;
				next_r.stopped_exec = 1'b0;
				next_r.indiv        = rise[mot_pkg::CB_INDIV];
				next_r.seq          = r.cmd[mot_pkg::CB_SEQ_EN] ? r.seq_no : r.seq;
				next_r.timer        = 32'(STEP_CYCLES);
			end
		end
		if (rise[mot_pkg::CB_MRESET]) begin
			next_r.ack[mot_pkg::CB_MRESET] = 1'b1;
			next_r.mcode  = 16'h0000;
			next_r.strobe = 1'b0;
		end
		if (rise[mot_pkg::CB_TEACH]) begin
			next_r.ack[mot_pkg::CB_TEACH] = 1'b1;
			next_r.teach_we   = 1'b1;
			next_r.teach_data = i_present_pos;
		end
		// Sequencer
		case (r.state)
			ST_RUN: begin
				if (i_seq_error) begin
					next_r.state        = ST_IDLE;
					next_r.stopped_exec = 1'b1;
				end else if (r.timer != 32'h0000_0000) begin
					next_r.timer = r.timer - 32'h0000_0001;
				end else if (!r.strobe && !r.axis_s2 && !rise[mot_pkg::CB_STOP]) begin
					if (i_seq_code != 16'h0000) begin
						next_r.mcode  = i_seq_code;
						next_r.strobe = 1'b1;
					end
					if (i_seq_end || r.seq == SEQ_LAST) begin
						next_r.state     = ST_IDLE;
						next_r.completed = 1'b1;
					end else begin
						next_r.seq   = r.seq + 16'h0001;
						next_r.timer = 32'(STEP_CYCLES);
						// Individual start pauses after every sequence but END
						if (r.indiv) begin
							next_r.state = ST_IDLE;
						end
					end
				end
			end
			ST_DECEL: begin
				if (r.timer != 32'h0000_0000) begin
					next_r.timer = r.timer - 32'h0000_0001;
				end else begin
					next_r.state        = ST_IDLE;
					next_r.stopped_exec = 1'b1;
				end
			end
			ST_IDLE: begin
			end
			default: next_r.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign o_wb_dat     = r.rdata;
	assign o_wb_ack     = r.wb_ack;
	assign o_seq_index  = r.seq;
	assign o_running    = (r.state == ST_RUN);
	assign o_teach_we   = r.teach_we;
	assign o_teach_addr = r.teach_no;
	assign o_teach_data = r.teach_data;

	// Assertions
	ack_drop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		$fell(r.cmd[mot_pkg::CB_START]) |=> !r.ack[mot_pkg::CB_START]) else $error("ack stuck");
	start_ack_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(rise[mot_pkg::CB_START] && !rise[mot_pkg::CB_STOP] && r.state != ST_DECEL)
		|=> r.ack[mot_pkg::CB_START]) else $error("start not acked");
	decel_block_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(r.state == ST_DECEL && !r.ack[mot_pkg::CB_START]) |=> !r.ack[mot_pkg::CB_START])
		else $error("start acked in decel");
	stop_decel_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(rise[mot_pkg::CB_STOP] && r.state == ST_RUN) |=> status[mot_pkg::SB_STOP_IN] && r.ack[15])
		else $error("stop not taken");
	busy_ok_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		status[mot_pkg::SB_BUSY] != status[mot_pkg::SB_START_OK]) else $error("busy and enable");
	multi_start_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(rise[mot_pkg::CB_START] && busy && !rise[15] && r.state != ST_DECEL) |=> r.invalid)
		else $error("multi start missed");
	code_reset_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rise[mot_pkg::CB_MRESET] |=> (r.mcode == 16'h0000) && !r.strobe) else $error("code kept");
	teach_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rise[mot_pkg::CB_TEACH] |=> o_teach_we && r.teach_data == $past(i_present_pos))
		else $error("teach lost");

	// Bus answer: one registered pulse per taken request
	wb_answer_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
		else $error("bus request not answered");
	ack_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		o_wb_ack |=> !o_wb_ack)
		else $error("bus ack longer than one cycle");

	// Each accepted command raises its own acknowledge bit
	seq_ack_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rise[mot_pkg::CB_SEQ_EN] |=> r.ack[mot_pkg::CB_SEQ_EN])
		else $error("sequence enable not acked");
	indiv_ack_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(rise[mot_pkg::CB_INDIV] && !rise[mot_pkg::CB_STOP] && r.state != ST_DECEL)
		|=> r.ack[mot_pkg::CB_INDIV])
		else $error("individual start not acked");
	mreset_ack_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rise[mot_pkg::CB_MRESET] |=> r.ack[mot_pkg::CB_MRESET])
		else $error("code reset not acked");
	teach_ack_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rise[mot_pkg::CB_TEACH] |=> r.ack[mot_pkg::CB_TEACH])
		else $error("teach not acked");
	stop_ack_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rise[mot_pkg::CB_STOP] |=> r.ack[mot_pkg::CB_STOP])
		else $error("stop not acked");

	// Starting point and run state of an accepted start
	seq_start_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(rise[mot_pkg::CB_START] && r.cmd[mot_pkg::CB_SEQ_EN] && !busy && !rise[mot_pkg::CB_STOP])
		|=> o_seq_index == $past(r.seq_no))
		else $error("start sequence not taken");
	run_start_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(rise[mot_pkg::CB_START] && !busy && !rise[mot_pkg::CB_STOP]) |=> o_running)
		else $error("start did not run");

	// Status flags against the sequencer state
	busy_run_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(r.state != ST_IDLE) |-> status[mot_pkg::SB_BUSY])
		else $error("busy low while running");
	start_ok_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		status[mot_pkg::SB_START_OK] |-> (r.state == ST_IDLE) && !r.axis_s2 && !r.strobe)
		else $error("start enabled while busy");
	decel_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		$rose(status[mot_pkg::SB_STOP_IN]) |-> status[mot_pkg::SB_STOP_IN][*2])
		else $error("stop input flag too short");
	strobe_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(r.strobe && !rise[mot_pkg::CB_MRESET]) |=> r.strobe)
		else $error("strobe dropped without reset");
	done_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		$rose(r.completed) |-> (r.state == ST_IDLE))
		else $error("completed while running");
	stopped_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		$rose(r.stopped_exec) |-> (r.state == ST_IDLE))
		else $error("stop executed while running");
	status_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(status & 16'hCEAC) == 16'h0000)
		else $error("unused status bit set");
	unused_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(r.cmd & ~mot_pkg::CMD_USED_MASK) == 16'h0000) else $error("unused cmd bit");
	start_c: cover property (@(posedge i_clk_sys) disable iff (i_rst) r.state == ST_RUN);
	decel_c: cover property (@(posedge i_clk_sys) disable iff (i_rst) r.state == ST_DECEL);
	done_c:  cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(r.completed));
	indiv_c: cover property (@(posedge i_clk_sys) disable iff (i_rst) r.state == ST_RUN && r.indiv);
	strobe_c: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(r.strobe));
endmodule
`default_nettype wire

// File: testbench/mot_motion_model.sv
// Motion side model driven from the run state of the task block
`default_nettype none
module mot_motion_model (
	// Design side
	input  wire logic        i_clk_sys,
	input  wire logic        i_running,
	input  wire logic [15:0] i_seq_index,
	// Bench control
	input  wire logic [15:0] i_end_at,
	// Motion answers
	output logic             o_axis_busy,
	output logic      [31:0] o_present_pos,
	output logic      [15:0] o_seq_code,
	output logic             o_seq_end,
	output logic             o_seq_error
);
	timeunit 1ns;
	timeprecision 1ns;
	// Axis lags the run state by one cycle, as a real drive would
	always_ff @(posedge i_clk_sys) begin
		o_axis_busy <= i_running;
	end
	assign o_present_pos = 32'h0001_2345;
	// Aux code only on one sequence, so strobe stays out of other runs
	assign o_seq_code    = (i_seq_index == 16'h0020) ? 16'h0009 : 16'h0000;
	assign o_seq_end     = (i_seq_index == i_end_at);
	assign o_seq_error   = 1'b0;
endmodule
`default_nettype wire

// File: testbench/mot_task_cmd_tb.sv
// Self-checking bench for the task command block
`default_nettype none
module mot_task_cmd_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst, cyc, stb, we, busy, run, tw, send, serr;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, rdat, pos, tdat;
	logic [15:0] code, idx, taddr, end_at;
	logic        ack;
	int          fail_count, n_compared;

	mot_task_cmd #(.DECEL_CYCLES(40), .STEP_CYCLES(2), .SEQ_LAST(16'h00FF)) u_mot_task_cmd (
		.i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_axis_busy(busy), .i_present_pos(pos), .i_seq_code(code), .i_seq_end(send),
		.i_seq_error(serr), .o_seq_index(idx), .o_running(run), .o_teach_we(tw),
		.o_teach_addr(taddr), .o_teach_data(tdat));
	mot_motion_model u_mot_motion_model (
		.i_clk_sys(clk), .i_running(run), .i_seq_index(idx), .i_end_at(end_at),
		.o_axis_busy(busy), .o_present_pos(pos), .o_seq_code(code), .o_seq_end(send),
		.o_seq_error(serr));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("Error %0t: saw %h expected %h", $time, s, e);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		// Look between edges; ack and data are then settled for the next rising edge
		forever begin
			@(negedge clk);
			if (ack === 1'b1) break;
		end
		r = rdat;
		@(posedge clk);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] r;
		wb(1'b1, a, {16'h0000, d}, r);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		wb(1'b0, a, 32'h0000_0000, r);
		chk(r & m, e);
	endtask

	// Polls until the masked field matches; bounded so a stuck flag fails
	task automatic poll(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		logic [31:0] r;
		int          n;
		n = 0;
		do begin
			wb(1'b0, a, 32'h0000_0000, r);
			n++;
		end while ((r[15:0] & m) !== e && n < 200);
		chk({16'h0000, r[15:0] & m}, {16'h0000, e});
	endtask

	task automatic t_reset();
		rd(mot_pkg::OFS_STAT, 32'hFFFF_FFFF, 32'h0000_0002);
		rd(mot_pkg::OFS_ACK, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask

	task automatic t_unused();
		wr(mot_pkg::OFS_CMD, 16'h7FC8);
		rd(mot_pkg::OFS_CMD, 32'hFFFF_FFFF, 32'h0000_0000);
		rd(mot_pkg::OFS_ACK, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(mot_pkg::OFS_ACK, 16'hFFFF);
		rd(mot_pkg::OFS_ACK, 32'hFFFF_FFFF, 32'h0000_0000);
		rd(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask

	task automatic t_teach();
		wr(mot_pkg::OFS_TEACH, 16'h0003);
		rd(mot_pkg::OFS_TEACH, 32'hFFFF_FFFF, 32'h0000_0003);
		wr(mot_pkg::OFS_CMD, 16'h0020);
		poll(mot_pkg::OFS_ACK, 16'hFFFF, 16'h0020);
		chk({16'h0000, taddr}, 32'h0000_0003);
		rd(mot_pkg::OFS_TPOS, 32'hFFFF_FFFF, 32'h0001_2345);
		wr(mot_pkg::OFS_CMD, 16'h0000);
		poll(mot_pkg::OFS_ACK, 16'hFFFF, 16'h0000);
	endtask

	task automatic t_run();
		end_at <= 16'h0005;
		wr(mot_pkg::OFS_SEQ, 16'h0005);
		rd(mot_pkg::OFS_SEQ, 32'hFFFF_FFFF, 32'h0000_0005);
		wr(mot_pkg::OFS_CMD, 16'h0003);
		poll(mot_pkg::OFS_ACK, 16'h0003, 16'h0003);
		rd(mot_pkg::OFS_POS, 32'hFFFF_FFFF, 32'h0000_0005);
		wr(mot_pkg::OFS_CMD, 16'h0000);
		poll(mot_pkg::OFS_STAT, 16'h2003, 16'h2002);
	endtask

	task automatic t_stop();
		end_at <= 16'h00FF;
		wr(mot_pkg::OFS_SEQ, 16'h0030);
		wr(mot_pkg::OFS_CMD, 16'h0003);
		poll(mot_pkg::OFS_STAT, 16'h0003, 16'h0001);
		wr(mot_pkg::OFS_CMD, 16'h0000);
		wr(mot_pkg::OFS_CMD, 16'h0002);
		poll(mot_pkg::OFS_STAT, 16'h0100, 16'h0100);
		wr(mot_pkg::OFS_CMD, 16'h8000);
		poll(mot_pkg::OFS_STAT, 16'h0010, 16'h0010);
		wr(mot_pkg::OFS_CMD, 16'h8002);
		rd(mot_pkg::OFS_ACK, 32'h0000_8002, 32'h0000_8000);
		wr(mot_pkg::OFS_CMD, 16'h8000);
		poll(mot_pkg::OFS_STAT, 16'h1011, 16'h1000);
		wr(mot_pkg::OFS_CMD, 16'h0000);
	endtask

	task automatic t_aux();
		wr(mot_pkg::OFS_SEQ, 16'h0020);
		wr(mot_pkg::OFS_CMD, 16'h0005);
		poll(mot_pkg::OFS_ACK, 16'h0005, 16'h0005);
		wr(mot_pkg::OFS_CMD, 16'h0000);
		poll(mot_pkg::OFS_STAT, 16'h0141, 16'h0041);
		wr(mot_pkg::OFS_CMD, 16'h0010);
		poll(mot_pkg::OFS_ACK, 16'h0010, 16'h0010);
		wr(mot_pkg::OFS_CMD, 16'h0000);
		poll(mot_pkg::OFS_STAT, 16'h0043, 16'h0002);
	endtask

	task automatic results();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Whole run needs under two hundred cycles; this is ample headroom
	initial begin
		#400000;
		fail_count++;
		results();
	end

	initial begin
		fail_count = 0;
		n_compared = 0;
		rst = 1'b1;
		{cyc, stb, we} = 3'b000;
		adr = 8'h00;
		sel = 4'hF;
		dat = 32'h0000_0000;
		end_at = 16'h0000;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_unused();
		t_teach();
		t_run();
		t_stop();
		t_aux();
		results();
	end
endmodule
`default_nettype wire
